//--- rtl/hspc_strap_config.sv
`timescale 1ns/1ps
module hspc_strap_config
    import hspc_pkg::*;
(
    input  wire logic I_MCLK,
    input  wire logic I_SRST,
    input  wire logic I_PORT0_POS_DISABLE_STRAP,
    input  wire logic I_PORT0_NEG_DISABLE_STRAP,
    input  wire logic I_PORT3_POS_DISABLE_STRAP,
    input  wire logic I_PORT3_NEG_DISABLE_STRAP,
    input  wire logic I_PORT4_POS_DISABLE_STRAP,
    input  wire logic I_PORT4_NEG_DISABLE_STRAP,
    input  wire logic I_SPI_RATE_SELECT_STRAP,
    input  wire logic I_SWAP_ENABLE,
    input  wire logic I_SPI_ENABLE,
    input  wire logic I_POWER_DOWN,
    input  wire logic I_SUSPEND,
    input  wire logic I_SPI_SELECT,
    output logic      O_CONFIG_VALID,
    output logic      O_PORT0_POS_ENABLE,
    output logic      O_PORT0_NEG_ENABLE,
    output logic      O_PORT0_HSIC_MODE,
    output logic      O_PORT3_ENABLE,
    output logic      O_PORT4_ENABLE,
    output logic      O_SPI_RATE_60MHZ,
    output logic      O_UPSTREAM_ON_PORT1_PINS,
    output logic      O_PORT1_ON_UPSTREAM_PINS,
    output logic      O_SPI_CE_N,
    output logic      O_SPI_RATE_SELECT_STRAP_O,
    output logic      O_SPI_RATE_SELECT_STRAP_OE
);
    logic [STRAP_WIDTH-1:0] strap_pins;
    logic [STRAP_WIDTH-1:0] strap_sync;
    logic [STRAP_WIDTH-1:0] strap;
    logic [STRAP_WIDTH-1:0] next_strap;
    logic                   in_reset;
    logic                   next_in_reset;
    logic                   valid;
    logic                   next_valid;
    logic                   swap;
    logic                   next_swap;
    logic                   ce_n;
    logic                   next_ce_n;
    logic                   spd_o;
    logic                   next_spd_o;
    logic                   spd_oe;
    logic                   next_spd_oe;

    assign strap_pins = {I_SPI_RATE_SELECT_STRAP,
                         I_PORT4_NEG_DISABLE_STRAP, I_PORT4_POS_DISABLE_STRAP,
                         I_PORT3_NEG_DISABLE_STRAP, I_PORT3_POS_DISABLE_STRAP,
                         I_PORT0_NEG_DISABLE_STRAP, I_PORT0_POS_DISABLE_STRAP};

    hspc_sync #(
        .WIDTH   (STRAP_WIDTH)
    ) u_sync (
        .i_clk   (I_MCLK),
        .i_srst  (I_SRST),
        .i_async (strap_pins),
        .o_sync  (strap_sync)
    );

    // The synchroniser is flushed by reset, so capture waits until it refills.
    logic [1:0] fill;
    logic [1:0] next_fill;

    always_comb begin
        next_strap    = strap;
        next_valid    = valid;
        next_in_reset = 1'h0;
        next_fill     = fill;
        if (I_SRST) begin
            next_in_reset = 1'h1;
            next_valid    = 1'h0;
            next_fill     = 2'h0;
            next_strap    = STRAP_RESET;
        end else if (!valid) begin
            if (fill == SYNC_FILL_COUNT) begin
                next_strap = strap_sync;
                next_valid = 1'h1;
            end else begin
                next_fill = fill + 2'h1;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        strap    <= next_strap;
        valid    <= next_valid;
        in_reset <= next_in_reset;
        fill     <= next_fill;
    end

    // Pin controls follow their inputs one edge later and sit in their safe state in reset.
    always_comb begin
        next_swap   = I_SRST ? 1'h0 : I_SWAP_ENABLE;
        // Select is active low; power-down parks it high while SPI is enabled.
        next_ce_n   = 1'h1;
        next_spd_o  = 1'h0;
        next_spd_oe = 1'h0;
        if (!I_SRST) begin
            if (I_SPI_ENABLE && I_POWER_DOWN) begin
                next_ce_n = 1'h1;
            end else begin
                next_ce_n = !(I_SPI_ENABLE && I_SPI_SELECT);
            end
            if (valid && I_SUSPEND) begin
                next_spd_oe = (strap[BIT_SPD] == SPD_STRAP_30MHZ);
                next_spd_o  = 1'h0;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        swap   <= next_swap;
        ce_n   <= next_ce_n;
        spd_o  <= next_spd_o;
        spd_oe <= next_spd_oe;
    end

    // Decodes stay low until capture, so nothing downstream acts on flushed straps.
    assign O_CONFIG_VALID     = valid;
    assign O_PORT0_POS_ENABLE = valid && (strap[BIT_P0_POS] == STRAP_ENABLED);
    assign O_PORT0_NEG_ENABLE = valid && (strap[BIT_P0_NEG] == STRAP_ENABLED);
    assign O_PORT0_HSIC_MODE  = valid && (strap[BIT_P0_POS] == STRAP_DISABLED)
                                      && (strap[BIT_P0_NEG] == STRAP_DISABLED);
    assign O_PORT3_ENABLE     = valid && !((strap[BIT_P3_POS] == STRAP_DISABLED)
                                      && (strap[BIT_P3_NEG] == STRAP_DISABLED));
    assign O_PORT4_ENABLE     = valid && !((strap[BIT_P4_POS] == STRAP_DISABLED)
                                      && (strap[BIT_P4_NEG] == STRAP_DISABLED));
    assign O_SPI_RATE_60MHZ   = valid && (strap[BIT_SPD] == SPD_STRAP_60MHZ);
    assign O_UPSTREAM_ON_PORT1_PINS   = swap;
    assign O_PORT1_ON_UPSTREAM_PINS   = swap;
    assign O_SPI_CE_N                 = ce_n;
    assign O_SPI_RATE_SELECT_STRAP_O  = spd_o;
    assign O_SPI_RATE_SELECT_STRAP_OE = spd_oe;

    sequence s_captured;
        !valid ##1 valid;
    endsequence

    sequence s_release;
        in_reset ##1 !in_reset;
    endsequence

    // Capture: straps are taken once after release and then held until the next reset.
    chk_strap_hold: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        valid |=> ($stable(strap) && valid))
        else $error("Latched straps changed without reset.");
    chk_capture_delay: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        $fell(in_reset) |-> ##[1:3] valid)
        else $error("Straps not captured after reset release.");
    chk_capture_value: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        s_captured |-> strap == $past(strap_sync))
        else $error("Captured straps differ from synchronised pins.");
    chk_capture_wait: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        s_release |-> !valid ##1 !valid ##1 valid)
        else $error("Straps captured at the wrong edge.");
    chk_strap_reset: assert property (@(posedge I_MCLK)
        I_SRST |=> (strap == STRAP_RESET))
        else $error("Latched straps not cleared by reset.");
    chk_decode_gated: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        !valid |-> !(O_PORT0_POS_ENABLE || O_PORT0_NEG_ENABLE || O_PORT0_HSIC_MODE
                     || O_PORT3_ENABLE || O_PORT4_ENABLE || O_SPI_RATE_60MHZ))
        else $error("Decoded outputs active before capture.");

    // Decode of the latched straps.
    chk_port0_lines: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        valid |-> ((O_PORT0_POS_ENABLE == !strap[BIT_P0_POS])
                   && (O_PORT0_NEG_ENABLE == !strap[BIT_P0_NEG])))
        else $error("Port 0 line enable decode wrong.");
    chk_hsic_decode: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        O_PORT0_HSIC_MODE |-> (!O_PORT0_POS_ENABLE && !O_PORT0_NEG_ENABLE))
        else $error("HSIC mode with a port 0 line enabled.");
    chk_hsic_strap: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        valid |-> (O_PORT0_HSIC_MODE == (strap[BIT_P0_POS] && strap[BIT_P0_NEG])))
        else $error("HSIC mode decode wrong.");
    chk_port3_decode: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        valid |-> (O_PORT3_ENABLE != (strap[BIT_P3_POS] && strap[BIT_P3_NEG])))
        else $error("Port 3 enable decode wrong.");
    chk_port4_decode: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        valid |-> (O_PORT4_ENABLE != (strap[BIT_P4_POS] && strap[BIT_P4_NEG])))
        else $error("Port 4 enable decode wrong.");
    chk_rate_decode: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        valid |-> (O_SPI_RATE_60MHZ == strap[BIT_SPD]))
        else $error("SPI rate decode wrong.");

    // Pin controls.
    chk_reset_state: assert property (@(posedge I_MCLK)
        I_SRST |=> (!O_CONFIG_VALID && O_SPI_CE_N && !O_SPI_RATE_SELECT_STRAP_OE && !O_UPSTREAM_ON_PORT1_PINS))
        else $error("Outputs not in their reset state.");
    chk_ce_powerdown: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        (I_SPI_ENABLE && I_POWER_DOWN) |=> O_SPI_CE_N)
        else $error("Chip enable not high in power-down.");
    chk_pd_priority: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        (I_SPI_ENABLE && I_POWER_DOWN && I_SPI_SELECT) |=> O_SPI_CE_N)
        else $error("Select overrode power-down.");
    chk_ce_select: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        (I_SPI_ENABLE && !I_POWER_DOWN && I_SPI_SELECT) |=> !O_SPI_CE_N)
        else $error("Chip enable not low when selected.");
    chk_ce_idle: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        (!I_SPI_ENABLE || !I_SPI_SELECT) |=> O_SPI_CE_N)
        else $error("Chip enable low without a select.");
    chk_spd_release: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        (valid && I_SUSPEND && strap[BIT_SPD]) |=> !O_SPI_RATE_SELECT_STRAP_OE)
        else $error("Speed pin driven in suspend after strap 1.");
    chk_spd_drive_low: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        (valid && I_SUSPEND && !strap[BIT_SPD]) |=>
        (O_SPI_RATE_SELECT_STRAP_OE && !O_SPI_RATE_SELECT_STRAP_O))
        else $error("Speed pin not driven low in suspend after strap 0.");
    chk_spd_awake: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        !I_SUSPEND |=> !O_SPI_RATE_SELECT_STRAP_OE)
        else $error("Speed pin driven outside suspend.");
    chk_spd_gated: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        !valid |=> !O_SPI_RATE_SELECT_STRAP_OE)
        else $error("Speed pin driven before capture.");
    chk_swap_follow: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        I_SWAP_ENABLE |=> (O_UPSTREAM_ON_PORT1_PINS && O_PORT1_ON_UPSTREAM_PINS))
        else $error("Swap not applied.");
    chk_swap_clear: assert property (@(posedge I_MCLK) disable iff (I_SRST)
        !I_SWAP_ENABLE |=> !(O_UPSTREAM_ON_PORT1_PINS || O_PORT1_ON_UPSTREAM_PINS))
        else $error("Swap applied while not requested.");
endmodule // hspc_strap_config

//--- shared/hspc_pkg.sv
// Functional notes
// - Names ending _n are active low.
// - Port 0 line strap: 0 enabled, 1 disabled.
// - Both port 0 straps high select HSIC.
// - Port 3 disabled only when both straps high.
// - Port 4 disabled only when both straps high.
// - Optional upstream and port 1 swap.
// - Chip enable low selects; high in power-down.
// - Speed strap 0 gives 30MHz, 1 gives 60MHz.
// - Speed strap 1: pin released in suspend.
// - Speed strap 0: pin driven low in suspend.
package hspc_pkg;
    localparam logic       STRAP_ENABLED   = 1'h0;
    localparam logic       STRAP_DISABLED  = 1'h1;
    localparam logic       SPD_STRAP_30MHZ = 1'h0;
    localparam logic       SPD_STRAP_60MHZ = 1'h1;
    localparam int         SPI_RATE_LOW_MHZ  = 30;
    localparam int         SPI_RATE_HIGH_MHZ = 60;
    localparam logic [6:0] STRAP_RESET     = 7'h00;
    localparam int         STRAP_WIDTH     = 7;
    localparam int         BIT_P0_POS      = 0;
    localparam int         BIT_P0_NEG      = 1;
    localparam int         BIT_P3_POS      = 2;
    localparam int         BIT_P3_NEG      = 3;
    localparam int         BIT_P4_POS      = 4;
    localparam int         BIT_P4_NEG      = 5;
    localparam int         BIT_SPD         = 6;
    localparam logic [1:0] SYNC_FILL_COUNT = 2'h2;
endpackage

//--- rtl/hspc_sync.sv
`timescale 1ns/1ps
module hspc_sync
    import hspc_pkg::*;
#(
    parameter int WIDTH = 7
) (
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = i_async;
        next_sync = meta;
        if (i_srst) begin
            next_meta = STRAP_RESET;
            next_sync = STRAP_RESET;
        end
    end

    always_ff @(posedge i_clk) begin
        meta   <= next_meta;
        o_sync <= next_sync;
    end
endmodule // hspc_sync

//--- verif/hspc_board_model.sv
`timescale 1ns/1ps
module hspc_board_model (
    input  wire logic [6:0] i_straps,
    input  wire logic       i_spd_o,
    input  wire logic       i_spd_oe,
    output logic      [6:0] o_pins
);
    // Resistors set the strap levels, and a released rate pin falls back to its resistor.
    assign o_pins[5:0] = i_straps[5:0];
    assign o_pins[6]   = i_spd_oe ? i_spd_o : i_straps[6];
endmodule // hspc_board_model

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import hspc_pkg::*;
    logic       clk = 1'h0;
    logic       srst = 1'h1;
    logic [6:0] straps = 7'h00;
    logic       swap = 1'h0, spi_en = 1'h0, pd = 1'h0, susp = 1'h0, sel = 1'h0;
    logic [6:0] pins;
    logic       valid, p0p, p0n, hsic, p3, p4, r60, up1, p1up, ce_n, spd_o, spd_oe;
    int         failures = 0;
    int         total_checks = 0;
    int         cycles = 0;
    logic [6:0] pats [7] = '{7'h00, 7'h7F, 7'h01, 7'h02, 7'h15, 7'h2A, 7'h4C};
    hspc_board_model brd_u (.i_straps(straps), .i_spd_o(spd_o), .i_spd_oe(spd_oe), .o_pins(pins));
    hspc_strap_config dut_u (.I_MCLK(clk), .I_SRST(srst),
        .I_PORT0_POS_DISABLE_STRAP(pins[0]), .I_PORT0_NEG_DISABLE_STRAP(pins[1]),
        .I_PORT3_POS_DISABLE_STRAP(pins[2]), .I_PORT3_NEG_DISABLE_STRAP(pins[3]),
        .I_PORT4_POS_DISABLE_STRAP(pins[4]), .I_PORT4_NEG_DISABLE_STRAP(pins[5]),
        .I_SPI_RATE_SELECT_STRAP(pins[6]), .I_SWAP_ENABLE(swap), .I_SPI_ENABLE(spi_en),
        .I_POWER_DOWN(pd), .I_SUSPEND(susp), .I_SPI_SELECT(sel), .O_CONFIG_VALID(valid),
        .O_PORT0_POS_ENABLE(p0p), .O_PORT0_NEG_ENABLE(p0n), .O_PORT0_HSIC_MODE(hsic),
        .O_PORT3_ENABLE(p3), .O_PORT4_ENABLE(p4), .O_SPI_RATE_60MHZ(r60),
        .O_UPSTREAM_ON_PORT1_PINS(up1), .O_PORT1_ON_UPSTREAM_PINS(p1up), .O_SPI_CE_N(ce_n),
        .O_SPI_RATE_SELECT_STRAP_O(spd_o), .O_SPI_RATE_SELECT_STRAP_OE(spd_oe));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop();
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    // Stimulus changes on a rising edge; outputs of the next edge are read mid-cycle.
    task automatic step();
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic reset_with(input logic [6:0] p);
        @(posedge clk);
        srst <= 1'h1;
        straps <= p;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(valid, 1'h0, "valid in reset");
        chk(ce_n, 1'h1, "select in reset");
        chk(spd_oe, 1'h0, "rate pin driven in reset");
        chk(p0p | p0n | hsic | p3 | p4 | r60, 1'h0, "decode before capture");
        chk(up1 | p1up, 1'h0, "swap in reset");
        @(posedge clk);
        srst <= 1'h0;
        repeat (2) step();
        chk(valid, 1'h0, "valid early");
        step();
        chk(valid, 1'h1, "valid late");
    endtask

    task automatic check_decode(input logic [6:0] p);
        chk(p0p, ~p[0], "port0 pos enable");
        chk(p0n, ~p[1], "port0 neg enable");
        chk(hsic, p[0] & p[1], "hsic mode");
        chk(p3, ~(p[2] & p[3]), "port3 enable");
        chk(p4, ~(p[4] & p[5]), "port4 enable");
        chk(r60, p[6], "spi rate");
    endtask

    task automatic t_straps();
        foreach (pats[i]) begin
            reset_with(pats[i]);
            check_decode(pats[i]);
            @(posedge clk);
            straps <= ~pats[i];
            repeat (4) step();
            check_decode(pats[i]);
        end
    endtask

    task automatic t_spi();
        reset_with(7'h00);
        @(posedge clk);
        spi_en <= 1'h1;
        sel <= 1'h1;
        step();
        chk(ce_n, 1'h0, "slave not selected");
        @(posedge clk);
        pd <= 1'h1;
        step();
        chk(ce_n, 1'h1, "select in power-down");
        @(posedge clk);
        pd <= 1'h0;
        spi_en <= 1'h0;
        step();
        chk(ce_n, 1'h1, "select while disabled");
        @(posedge clk);
        spi_en <= 1'h1;
        sel <= 1'h0;
        step();
        chk(ce_n, 1'h1, "select while idle");
    endtask

    task automatic t_suspend(input logic sp);
        reset_with({sp, 6'h00});
        @(posedge clk);
        susp <= 1'h1;
        step();
        chk(spd_oe, ~sp, "rate pin enable in suspend");
        chk(pins[6], sp, "rate pin level in suspend");
        chk(spd_o, 1'h0, "rate pin drive level in suspend");
        @(posedge clk);
        susp <= 1'h0;
        step();
        chk(spd_oe, 1'h0, "rate pin enable after suspend");
    endtask

    task automatic t_swap();
        @(posedge clk);
        swap <= 1'h1;
        step();
        chk(up1, 1'h1, "upstream swap");
        chk(p1up, 1'h1, "port1 swap");
        @(posedge clk);
        swap <= 1'h0;
        step();
        chk(up1 | p1up, 1'h0, "swap release");
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        t_straps();
        t_spi();
        t_suspend(1'h0);
        t_suspend(1'h1);
        t_swap();
        report_and_stop();
    end
endmodule // tb_top
